/* File: src/irq_cfg_pkg.sv */
/*
  Package for the common interrupt mask and buffer configuration bank.
  Holds register offsets, field positions, reset values and timing counts.
  Assumes an 8-bit host register port with a 16-bit byte address.
*/
package irq_cfg_pkg;
  localparam logic [15:0] OFF_MAIN_EVENT_FLAGS = 16'h0015;
  localparam logic [15:0] OFF_MAIN_IRQ_MASK = 16'h0016;
  localparam logic [15:0] OFF_RETRY_TIME_HI = 16'h0017;
  localparam logic [15:0] OFF_RETRY_TIME_LO = 16'h0018;
  localparam logic [15:0] OFF_RETRY_COUNT = 16'h0019;
  localparam logic [15:0] OFF_RX_SIZES = 16'h001A;
  localparam logic [15:0] OFF_TX_SIZES = 16'h001B;
  localparam logic [15:0] OFF_WAKE_FLAGS = 16'h0020;
  localparam logic [15:0] OFF_WAKE_MASK = 16'h0021;
  localparam logic [15:0] OFF_ECHO_PERIOD = 16'h0028;

  localparam logic [7:0] RST_MAIN_IRQ_MASK = 8'h00;
  localparam logic [15:0] RST_RETRY_TIME = 16'h07D0;
  localparam logic [7:0] RST_RETRY_COUNT = 8'h08;
  localparam logic [7:0] RST_BUF_SIZES = 8'h55;
  localparam logic [7:0] RST_WAKE_MASK = 8'h00;
  localparam logic [7:0] RST_ECHO_PERIOD = 8'h28;

  localparam int ADDR_CLASH_BIT = 7;
  localparam int DEST_PORT_FAIL_BIT = 6;
  localparam int SESSION_END_BIT = 5;
  localparam int RESERVED_MAIN_BIT = 4;
  localparam logic [7:0] MAIN_MASK_USED = 8'hEF;
  localparam int MAGIC_PACKET_BIT = 0;
  localparam logic [7:0] WAKE_USED = 8'h01;
  localparam int SOCKETS = 4;

  localparam int RETRY_TIME_UNIT_US = 100;
  localparam int ECHO_PERIOD_UNIT_MS = 25;
  localparam int PEND_TICK_CLKS = 4;
  localparam logic [1:0] PEND_TICK_LAST = 2'(PEND_TICK_CLKS - 1);

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic addr_clash;
    logic dest_port_fail;
    logic session_end;
    logic [SOCKETS-1:0] socket_irq;
    logic magic_packet;
  } events_t;
endpackage

/* File: src/irq_pending_timer.sv */
/*
  Interrupt pending timer: reloads while the interrupt line is high-going
  and counts down by one every four system clocks down to zero.
  Assumes the reload value comes from a register on the same clock.
*/
`timescale 1ns/1ps
module irq_pending_timer #(
  parameter int WIDTH = 16
) (
  input wire logic system_clock_i,
  input wire logic arst_n_i,
  input wire logic reload_i,
  input wire logic [WIDTH-1:0] irq_pending_time_i,
  output logic expired_o
);
  logic [WIDTH-1:0] count_r;
  logic [1:0] tick_r;

  always_ff @(posedge system_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_r <= 2'h0;
    end else if (reload_i || tick_r == irq_cfg_pkg::PEND_TICK_LAST) begin
      tick_r <= 2'h0;
    end else begin
      tick_r <= tick_r + 2'h1;
    end
  end

  always_ff @(posedge system_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_r <= '0;
    end else if (reload_i) begin
      count_r <= irq_pending_time_i;
    end else if (count_r != '0 && tick_r == irq_cfg_pkg::PEND_TICK_LAST) begin
      count_r <= count_r - WIDTH'(1);
    end
  end

  assign expired_o = (count_r == '0);
endmodule // irq_pending_timer

/* File: src/irq_cfg_bank.sv */
/*
  Common register bank: interrupt masks, wake event flag and mask,
  retransmission defaults, buffer size fields and link echo period.
  Assumes a single-cycle 8-bit host register port on system_clock_i and event
  pulses from the protocol engines on the same clock.
*/
// Summary of operation
// - Mask bit 7 gates address clash event.
// - Mask bit 6 gates port unreachable event.
// - Mask bit 5 gates session termination event.
// - Mask bits 3:0 gate socket events.
// - Retry time default 2000, 100 us units.
// - Zero socket retry count reloads from default.
// - Rx sizes two bits per socket, reset 0x55.
// - Tx sizes same layout, reset 0x55.
// - Magic packet sets wake flag, write-one clears.
// - Interrupt needs flag, mask, expired pending timer.
// - Release interrupt when flag or mask clears.
// - Wake mask bit 0 enables, resets zero.
// - Echo period in 25 ms units, reset 40.
// - Pending timer reloads on release, counts per 4.
// - Global enable low holds interrupt high.
// - Events set main flags whatever the mask.
`timescale 1ns/1ps
module irq_cfg_bank #(
  parameter int SOCKETS = irq_cfg_pkg::SOCKETS
) (
  input wire logic system_clock_i,
  input wire logic arst_n_i,
  input wire irq_cfg_pkg::host_req_t host_req_i,
  output logic [7:0] host_rdata_o,
  output logic host_hit_o,
  input wire irq_cfg_pkg::events_t events_i,
  input wire logic [SOCKETS-1:0] socket_irq_clear_i,
  input wire logic global_irq_enable_i,
  input wire logic [15:0] irq_pending_time_i,
  input wire logic [SOCKETS-1:0] socket_retry_count_zero_i,
  output logic [SOCKETS-1:0] socket_retry_load_o,
  output logic [15:0] default_retry_time_o,
  output logic [7:0] default_retry_count_o,
  output logic [7:0] rx_buffer_sizes_o,
  output logic [7:0] tx_buffer_sizes_o,
  output logic [7:0] ppp_echo_period_o,
  output logic irq_out_low_o
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] main_irq_mask_r;
  logic [7:0] main_event_flags_r;
  logic [15:0] default_retry_time_r;
  logic [7:0] default_retry_count_r;
  logic [7:0] rx_buffer_sizes_r;
  logic [7:0] tx_buffer_sizes_r;
  logic [7:0] wake_event_flags_r;
  logic [7:0] wake_event_mask_r;
  logic [7:0] ppp_echo_period_r;
  logic [7:0] host_rdata_r;
  logic irq_low_r;
  logic [7:0] main_set;
  logic [7:0] main_clr;
  logic wr_hit;
  logic irq_cause;
  logic timer_expired;
  logic [7:0] wd;

  assign wd = host_req_i.wdata;

  function automatic logic wr_at(input logic [15:0] off);
    wr_at = host_req_i.wr && host_req_i.addr == off;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Plain configuration registers.
  always_ff @(posedge system_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      main_irq_mask_r <= irq_cfg_pkg::RST_MAIN_IRQ_MASK;
    end else if (wr_at(irq_cfg_pkg::OFF_MAIN_IRQ_MASK)) begin
      main_irq_mask_r <= wd & irq_cfg_pkg::MAIN_MASK_USED;
    end
  end

  always_ff @(posedge system_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      default_retry_time_r <= irq_cfg_pkg::RST_RETRY_TIME;
    end else if (wr_at(irq_cfg_pkg::OFF_RETRY_TIME_HI)) begin
      default_retry_time_r[15:8] <= wd;
    end else if (wr_at(irq_cfg_pkg::OFF_RETRY_TIME_LO)) begin
      default_retry_time_r[7:0] <= wd;
    end
  end

  always_ff @(posedge system_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      default_retry_count_r <= irq_cfg_pkg::RST_RETRY_COUNT;
    end else if (wr_at(irq_cfg_pkg::OFF_RETRY_COUNT)) begin
      default_retry_count_r <= wd;
    end
  end

  always_ff @(posedge system_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_buffer_sizes_r <= irq_cfg_pkg::RST_BUF_SIZES;
      tx_buffer_sizes_r <= irq_cfg_pkg::RST_BUF_SIZES;
    end else begin
      // The 8 KB budget is not checked; a bad setting is the host's fault.
      if (wr_at(irq_cfg_pkg::OFF_RX_SIZES)) begin
        rx_buffer_sizes_r <= wd;
      end
      if (wr_at(irq_cfg_pkg::OFF_TX_SIZES)) begin
        tx_buffer_sizes_r <= wd;
      end
    end
  end

  always_ff @(posedge system_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_event_mask_r <= irq_cfg_pkg::RST_WAKE_MASK;
    end else if (wr_at(irq_cfg_pkg::OFF_WAKE_MASK)) begin
      wake_event_mask_r <= wd & irq_cfg_pkg::WAKE_USED;
    end
  end

  always_ff @(posedge system_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ppp_echo_period_r <= irq_cfg_pkg::RST_ECHO_PERIOD;
    end else if (wr_at(irq_cfg_pkg::OFF_ECHO_PERIOD)) begin
      ppp_echo_period_r <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event flags. A set in the same cycle as a clear wins, so no event is lost.
  always_comb begin
    main_set = 8'h00;
    main_set[irq_cfg_pkg::ADDR_CLASH_BIT] = events_i.addr_clash;
    main_set[irq_cfg_pkg::DEST_PORT_FAIL_BIT] = events_i.dest_port_fail;
    main_set[irq_cfg_pkg::SESSION_END_BIT] = events_i.session_end;
    main_set[SOCKETS-1:0] = events_i.socket_irq;
    main_clr = 8'h00;
    if (wr_at(irq_cfg_pkg::OFF_MAIN_EVENT_FLAGS)) begin
      main_clr[7:5] = wd[7:5];
    end
    // Socket bits follow their socket status and clear on its notice.
    main_clr[SOCKETS-1:0] = socket_irq_clear_i;
  end

  always_ff @(posedge system_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      main_event_flags_r <= 8'h00;
    end else begin
      main_event_flags_r <= ((main_event_flags_r & ~main_clr) | main_set)
        & irq_cfg_pkg::MAIN_MASK_USED;
    end
  end

  always_ff @(posedge system_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_event_flags_r <= 8'h00;
    end else if (events_i.magic_packet) begin
      wake_event_flags_r <= irq_cfg_pkg::WAKE_USED;
    end else if (wr_at(irq_cfg_pkg::OFF_WAKE_FLAGS) && wd[irq_cfg_pkg::MAGIC_PACKET_BIT]) begin
      wake_event_flags_r <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt line and pending timer.
  // Each mask bit gates the flag at the same position.
  assign irq_cause = global_irq_enable_i
    && (|(main_event_flags_r & main_irq_mask_r)
        || |(wake_event_flags_r & wake_event_mask_r));

  always_ff @(posedge system_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_low_r <= 1'b0;
    end else if (!irq_cause) begin
      irq_low_r <= 1'b0;
    end else if (timer_expired) begin
      irq_low_r <= 1'b1;
    end
  end

  // Reload while the line is low and its cause has gone, so the count starts afresh at release.
  irq_pending_timer #(
    .WIDTH(16)
  ) u_pend (
    .system_clock_i(system_clock_i),
    .arst_n_i(arst_n_i),
    .reload_i(irq_low_r && !irq_cause),
    .irq_pending_time_i(irq_pending_time_i),
    .expired_o(timer_expired)
  );

  assign irq_out_low_o = ~irq_low_r;

  ////////////////////////////////////////////////////////////////////////
  // Retransmission defaults seed sockets whose own count has run to zero.
  assign socket_retry_load_o = socket_retry_count_zero_i;
  assign default_retry_time_o = default_retry_time_r;
  assign default_retry_count_o = default_retry_count_r;
  assign rx_buffer_sizes_o = rx_buffer_sizes_r;
  assign tx_buffer_sizes_o = tx_buffer_sizes_r;
  assign ppp_echo_period_o = ppp_echo_period_r;

  ////////////////////////////////////////////////////////////////////////
  // Read port, registered; unmapped addresses read zero.
  always_ff @(posedge system_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_rdata_r <= 8'h00;
    end else if (host_req_i.rd) begin
      case (host_req_i.addr)
        irq_cfg_pkg::OFF_MAIN_EVENT_FLAGS: host_rdata_r <= main_event_flags_r;
        irq_cfg_pkg::OFF_MAIN_IRQ_MASK: host_rdata_r <= main_irq_mask_r;
        irq_cfg_pkg::OFF_RETRY_TIME_HI: host_rdata_r <= default_retry_time_r[15:8];
        irq_cfg_pkg::OFF_RETRY_TIME_LO: host_rdata_r <= default_retry_time_r[7:0];
        irq_cfg_pkg::OFF_RETRY_COUNT: host_rdata_r <= default_retry_count_r;
        irq_cfg_pkg::OFF_RX_SIZES: host_rdata_r <= rx_buffer_sizes_r;
        irq_cfg_pkg::OFF_TX_SIZES: host_rdata_r <= tx_buffer_sizes_r;
        irq_cfg_pkg::OFF_WAKE_FLAGS: host_rdata_r <= wake_event_flags_r;
        irq_cfg_pkg::OFF_WAKE_MASK: host_rdata_r <= wake_event_mask_r;
        irq_cfg_pkg::OFF_ECHO_PERIOD: host_rdata_r <= ppp_echo_period_r;
        default: host_rdata_r <= 8'h00;
      endcase
    end
  end

  always_comb begin
    case (host_req_i.addr)
      irq_cfg_pkg::OFF_MAIN_EVENT_FLAGS, irq_cfg_pkg::OFF_MAIN_IRQ_MASK,
      irq_cfg_pkg::OFF_RETRY_TIME_HI, irq_cfg_pkg::OFF_RETRY_TIME_LO,
      irq_cfg_pkg::OFF_RETRY_COUNT, irq_cfg_pkg::OFF_RX_SIZES,
      irq_cfg_pkg::OFF_TX_SIZES, irq_cfg_pkg::OFF_WAKE_FLAGS,
      irq_cfg_pkg::OFF_WAKE_MASK, irq_cfg_pkg::OFF_ECHO_PERIOD: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  assign host_hit_o = wr_hit && (host_req_i.wr || host_req_i.rd);
  assign host_rdata_o = host_rdata_r;
endmodule // irq_cfg_bank

/* File: test/irq_cfg_bank_assertions.sv */
/*
  Checker for the common interrupt mask and configuration bank.
  Assumes it is bound to irq_cfg_bank and sees only its ports.
*/
`timescale 1ns/1ps
module irq_cfg_bank_chk #(
  parameter int SOCKETS = 4
) (
  input wire logic system_clock_i,
  input wire logic arst_n_i,
  input wire irq_cfg_pkg::host_req_t host_req_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic host_hit_o,
  input wire logic [SOCKETS-1:0] socket_retry_count_zero_i,
  input wire logic [SOCKETS-1:0] socket_retry_load_o,
  input wire logic global_irq_enable_i,
  input wire logic [15:0] default_retry_time_o,
  input wire logic [7:0] rx_buffer_sizes_o,
  input wire logic [7:0] tx_buffer_sizes_o,
  input wire logic irq_out_low_o
);
  default clocking cb @(posedge system_clock_i); endclocking
  default disable iff (!arst_n_i);
  a_retry_load: assert property (socket_retry_load_o == socket_retry_count_zero_i)
    else $error("Retry load does not follow the zero count.");
  a_global_off: assert property (!global_irq_enable_i |=> irq_out_low_o)
    else $error("Interrupt low while globally disabled.");
  a_unmapped_zero: assert property (host_req_i.rd && !host_hit_o |=> host_rdata_o == 8'h00)
    else $error("Unmapped read is not zero.");
  a_mask_resv: assert property (host_req_i.rd && host_req_i.addr == 16'h0016 |=> !host_rdata_o[4])
    else $error("Reserved mask bit reads one.");
  a_wake_resv: assert property (host_req_i.rd && host_req_i.addr == 16'h0020
    |=> host_rdata_o[7:1] == 7'h00)
    else $error("Reserved wake flag bits read nonzero.");
  a_wmask_resv: assert property (host_req_i.rd && host_req_i.addr == 16'h0021
    |=> host_rdata_o[7:1] == 7'h00)
    else $error("Reserved wake mask bits read nonzero.");
  a_time_high: assert property (host_req_i.wr && host_req_i.addr == 16'h0017
    |=> default_retry_time_o[15:8] == $past(host_req_i.wdata))
    else $error("Retry time upper byte not taken.");
  a_time_low: assert property (host_req_i.wr && host_req_i.addr == 16'h0018
    |=> default_retry_time_o[7:0] == $past(host_req_i.wdata))
    else $error("Retry time lower byte not taken.");
  a_rx_sizes: assert property (host_req_i.wr && host_req_i.addr == 16'h001A
    |=> rx_buffer_sizes_o == $past(host_req_i.wdata))
    else $error("Receive sizes not taken.");
  a_tx_sizes: assert property (host_req_i.wr && host_req_i.addr == 16'h001B
    |=> tx_buffer_sizes_o == $past(host_req_i.wdata))
    else $error("Transmit sizes not taken.");
  c_irq_low: cover property ($fell(irq_out_low_o));
  c_wake_clear: cover property (host_req_i.wr && host_req_i.addr == 16'h0020);
  c_unmapped: cover property (host_req_i.rd && !host_hit_o);
endmodule // irq_cfg_bank_chk

bind irq_cfg_bank irq_cfg_bank_chk #(.SOCKETS(SOCKETS)) chk_i (
  .system_clock_i(system_clock_i), .arst_n_i(arst_n_i), .host_req_i(host_req_i),
  .host_rdata_o(host_rdata_o), .host_hit_o(host_hit_o),
  .socket_retry_count_zero_i(socket_retry_count_zero_i),
  .socket_retry_load_o(socket_retry_load_o), .global_irq_enable_i(global_irq_enable_i),
  .default_retry_time_o(default_retry_time_o), .rx_buffer_sizes_o(rx_buffer_sizes_o),
  .tx_buffer_sizes_o(tx_buffer_sizes_o), .irq_out_low_o(irq_out_low_o)
);

/* File: test/host_model.sv */
/*
  Host processor model: one-cycle register strobes, read data taken next edge.
  Assumes the bank answers a read in the cycle after the strobe.
*/
`timescale 1ns/1ps
module host_model (
  input wire logic system_clock_i,
  input wire logic [7:0] host_rdata_i,
  output irq_cfg_pkg::host_req_t host_req_o
);
  initial host_req_o = '0;
  // Between strobes the bus shows inverted leftovers, so a stale match is never kind.
  task automatic access(input logic wr, input logic [15:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    int kb;
    kb = 0;
    for (int s = 0; s < 4; s++) kb += 1 << wdata[2*s +: 2];
    if (wr && (addr == 16'h001A || addr == 16'h001B) && kb > 8) return;
    @(posedge system_clock_i);
    #1;
    host_req_o = {wr, !wr, addr, wdata};
    @(posedge system_clock_i);
    #1;
    rdata = host_rdata_i;
    host_req_o = {2'b00, ~addr, ~wdata};
  endtask
endmodule // host_model

/* File: test/irq_cfg_bank_test.sv */
/*
  Self-checking bench for the common interrupt mask and configuration bank.
  Assumes host_model for register traffic and the bound checker.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module irq_cfg_bank_test;
  logic system_clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  irq_cfg_pkg::host_req_t host_req;
  irq_cfg_pkg::events_t events = '0;
  logic [3:0] irq_clear = '0;
  logic irq_en = 1'b1;
  logic [15:0] pend_time = '0;
  logic [3:0] cnt_zero = '0;
  logic [3:0] load;
  logic [7:0] rdata, rcount, rx_sizes, tx_sizes, echo, d;
  logic [15:0] rtime;
  logic hit, irq_low;
  int err_total = 0;
  int compares = 0;
  irq_cfg_bank irq_cfg_bank_i (.system_clock_i(system_clock_i), .arst_n_i(arst_n_i),
    .host_req_i(host_req), .host_rdata_o(rdata), .host_hit_o(hit), .events_i(events),
    .socket_irq_clear_i(irq_clear), .global_irq_enable_i(irq_en),
    .irq_pending_time_i(pend_time), .socket_retry_count_zero_i(cnt_zero),
    .socket_retry_load_o(load), .default_retry_time_o(rtime),
    .default_retry_count_o(rcount), .rx_buffer_sizes_o(rx_sizes),
    .tx_buffer_sizes_o(tx_sizes), .ppp_echo_period_o(echo), .irq_out_low_o(irq_low));
  host_model host_model_i (.system_clock_i(system_clock_i), .host_rdata_i(rdata),
    .host_req_o(host_req));
  initial begin
    forever #2.5 system_clock_i = ~system_clock_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    logic [7:0] x;
    host_model_i.access(1'b1, a, v, x);
  endtask
  task automatic rd(input logic [15:0] a);
    host_model_i.access(1'b0, a, 8'h00, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge system_clock_i);
    #1;
  endtask
  task automatic pulse(input logic [7:0] v);
    cyc(1);
    events = irq_cfg_pkg::events_t'(v);
    cyc(1);
    events = '0;
  endtask
  // Bounded wait; the count lets a caller judge the pending delay too.
  task automatic wait_irq(input logic lvl, output int n);
    n = 0;
    while (irq_low !== lvl && n < 40) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic t_reset_values;
    logic [15:0] offs [10] = '{16'h16, 16'h17, 16'h18, 16'h19, 16'h1A, 16'h1B, 16'h20,
                                16'h21, 16'h28, 16'h30};
    logic [7:0] exp [10] = '{8'h00, 8'h07, 8'hD0, 8'h08, 8'h55, 8'h55, 8'h00, 8'h00,
                             8'h28, 8'h00};
    for (int i = 0; i < 10; i++) begin
      rd(offs[i]);
      `CHK(d, exp[i])
    end
    `CHK({rtime, rcount, echo}, 32'h07D0_0828)
  endtask
  task automatic t_write_read;
    wr(16'h0016, 8'hFF);
    rd(16'h0016);
    `CHK(d, 8'hEF)
    wr(16'h0017, 8'h13);
    wr(16'h0018, 8'h88);
    rd(16'h0017);
    `CHK({d, rtime}, 24'h13_1388)
    wr(16'h0019, 8'h03);
    cnt_zero = 4'hA;
    #1;
    `CHK({rcount, load}, 12'h03_A)
    wr(16'h001A, 8'h06);
    wr(16'h001B, 8'h90);
    `CHK({rx_sizes, tx_sizes}, 16'h0690)
    wr(16'h0021, 8'hFF);
    rd(16'h0021);
    `CHK(d, 8'h01)
    wr(16'h0028, 8'hC8);
    wr(16'h0030, 8'hFF);
    rd(16'h0030);
    `CHK({echo, d}, 16'hC8_00)
  endtask
  task automatic t_main_events;
    int n;
    wr(16'h0021, 8'h00);
    for (int b = 7; b >= 0; b--) if (b != 4) begin
      wr(16'h0016, 8'hEF & ~(8'h01 << b));
      pulse(b > 4 ? 8'h01 << b : 8'h02 << b);
      cyc(4);
      rd(16'h0015);
      `CHK({irq_low, d}, {1'b1, 8'h01 << b})
      wr(16'h0016, 8'h01 << b);
      wait_irq(1'b0, n);
      `CHK(irq_low, 1'b0)
      if (b > 4) wr(16'h0015, 8'h01 << b);
      else begin
        irq_clear = 4'(1 << b);
        cyc(1);
        irq_clear = '0;
      end
      wait_irq(1'b1, n);
      `CHK(irq_low, 1'b1)
    end
    wr(16'h0016, 8'h00);
  endtask
  task automatic t_wake;
    int n;
    pulse(8'h01);
    cyc(4);
    rd(16'h0020);
    `CHK({irq_low, d}, 9'h101)
    wr(16'h0021, 8'h01);
    wait_irq(1'b0, n);
    `CHK(irq_low, 1'b0)
    irq_en = 1'b0;
    cyc(3);
    `CHK(irq_low, 1'b1)
    irq_en = 1'b1;
    wr(16'h0021, 8'h00);
    // The line is registered, so it rises one edge after the mask write lands.
    cyc(1);
    `CHK(irq_low, 1'b1)
    wr(16'h0021, 8'h01);
    wait_irq(1'b0, n);
    pend_time = 16'h0003;
    wr(16'h0020, 8'h01);
    wait_irq(1'b1, n);
    `CHK(irq_low, 1'b1)
    pulse(8'h01);
    wait_irq(1'b0, n);
    `CHK(n >= 8 && n <= 12, 1'b1)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    cyc(16);
    arst_n_i = 1'b1;
    t_reset_values();
    t_write_read();
    t_main_events();
    t_wake();
    report_and_stop();
  end
  initial begin
    #50000;
    err_total++;
    report_and_stop();
  end
endmodule // irq_cfg_bank_test
